//--- rtl/lwu_defs.vh
// constants for the low leakage wake unit
`ifndef LWU_DEFS_VH
`define LWU_DEFS_VH

// power mode codes reported by the power management controller
`define LWU_MODE_W          3
`define LWU_MODE_RUN        3'h0
`define LWU_MODE_WAIT       3'h1
`define LWU_MODE_STOP       3'h2
`define LWU_MODE_RSTOP      3'h3
`define LWU_MODE_VLLSTOP    3'h4

// wake input counts
`define LWU_PIN_NUM         32
`define LWU_MOD_NUM         8

// pin wake input positions
`define LWU_PIN_PORT_LO     0
`define LWU_PIN_PORT_HI     15
`define LWU_PIN_USB_SUPPLY  26
`define LWU_PIN_USB_DP      27
`define LWU_PIN_USB_DM      28

// inputs with a source behind them; reserved ones never wake
`define LWU_PIN_VALID_MASK  32'h1c00ffff
`define LWU_USB_DATA_MASK   32'h18000000

// module wake input positions
`define LWU_MOD_LOW_POWER_TIMER       0
`define LWU_MOD_COMPARATOR_ZERO        1
`define LWU_MOD_RTC_ALARM   5
`define LWU_MOD_VALID_MASK  8'h23

// reset values
`define LWU_PIN_FLAG_RST    32'h00000000
`define LWU_MOD_FLAG_RST    8'h00

// synchroniser depth for pin inputs
`define LWU_SYNC_STAGES     2

`endif

//--- rtl/lwu_sync.v
// two flip-flop synchroniser for the pin wake inputs
`timescale 1ns/1ps
module lwu_sync #(
  parameter WIDTH = 32
) (
  input  wire             clk_i,
  input  wire             nrst_i,
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // first stage feeds only the second stage
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule

//--- rtl/lwu_top.v
// low leakage wake unit: arming, wake detection and wake request
`timescale 1ns/1ps
`include "lwu_defs.vh"

module lwu_top #(
  parameter PIN_NUM = `LWU_PIN_NUM,
  parameter MOD_NUM = `LWU_MOD_NUM
) (
  input  wire                   clk_i,
  input  wire                   nrst_i,
  input  wire [`LWU_MODE_W-1:0] power_mode_i,
  input  wire                   exit_start_i,
  input  wire [PIN_NUM-1:0]     pin_wake_input_i,
  input  wire [PIN_NUM-1:0]     pin_wake_enable_i,
  input  wire [MOD_NUM-1:0]     module_wake_input_i,
  input  wire [MOD_NUM-1:0]     module_wake_enable_i,
  input  wire                   usb_host_mode_i,
  input  wire                   wake_ack_i,
  output reg                    wake_req_o,
  output reg                    detecting_o,
  output reg                    core_irq_enable_o,
  output reg                    wake_irq_o,
  output reg  [PIN_NUM-1:0]     pin_wake_flag_o,
  output reg  [MOD_NUM-1:0]     module_wake_flag_o
);

  // one-hot states
  localparam [4:0] ST_IDLE    = 5'h01;
  localparam [4:0] ST_ARM_RS  = 5'h02;
  localparam [4:0] ST_ARM_VL  = 5'h04;
  localparam [4:0] ST_REQ     = 5'h08;
  localparam [4:0] ST_RECOVER = 5'h10;

  reg  [4:0]         state_r;
  reg  [4:0]         state_nxt;
  reg                vl_mode_r;
  reg                vl_mode_nxt;
  wire [PIN_NUM-1:0] pin_sync;
  wire [PIN_NUM-1:0] pin_qual;
  wire [MOD_NUM-1:0] mod_qual;
  wire               any_event;
  wire               detect;
  reg  [PIN_NUM-1:0] pin_flag_nxt;
  reg                req_nxt;
  reg                irq_nxt;
  reg                det_nxt;
  reg                core_irq_nxt;
  reg  [MOD_NUM-1:0] mod_flag_nxt;
  // entry detection: previous mode class and its rising edge
  reg                low_leak_r;
  wire               low_leak_now;
  wire               entry;

  // pins come from outside this clock domain
  lwu_sync #(
    .WIDTH (PIN_NUM)
  ) u_pin_sync (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .async_i (pin_wake_input_i),
    .sync_o  (pin_sync)
  );

  // low leakage mode test, shared by arming and irq gating
  function is_low_leak;
    input [`LWU_MODE_W-1:0] mode;
    begin
      is_low_leak = (mode == `LWU_MODE_RSTOP) || (mode == `LWU_MODE_VLLSTOP);
    end
  endfunction

  // reserved pins are masked off; usb data lines need host mode
  assign pin_qual = pin_sync & pin_wake_enable_i & `LWU_PIN_VALID_MASK
                  & ~(usb_host_mode_i ? {PIN_NUM{1'b0}} : `LWU_USB_DATA_MASK);

  // module flags only count with their enable bit set
  assign mod_qual = module_wake_input_i & module_wake_enable_i
                  & `LWU_MOD_VALID_MASK;

  assign any_event = (|pin_qual) | (|mod_qual);

  // a mode left at a stop code after the exit must not re-arm, so arm on the edge only
  assign low_leak_now = is_low_leak(power_mode_i);
  assign entry        = low_leak_now && !low_leak_r;

  // detection live only while armed, requesting or awaiting acknowledge
  assign detect = (state_r == ST_ARM_RS) || (state_r == ST_ARM_VL) ||
                  (state_r == ST_REQ) || (state_r == ST_RECOVER);

  always @* begin
    state_nxt   = state_r;
    vl_mode_nxt = vl_mode_r;
    case (state_r)
      ST_IDLE: begin
        // arm only on entry to a low leakage stop
        // a stop code that is already standing is not an entry
        if (entry && (power_mode_i == `LWU_MODE_RSTOP)) begin
          state_nxt   = ST_ARM_RS;
          vl_mode_nxt = 1'b0;
        end else if (entry && (power_mode_i == `LWU_MODE_VLLSTOP)) begin
          state_nxt   = ST_ARM_VL;
          vl_mode_nxt = 1'b1;
        end
      end
      ST_ARM_RS, ST_ARM_VL: begin
        // an event wins over a mode change in the same cycle
        if (any_event) begin
          state_nxt = ST_REQ;
        end else if (!is_low_leak(power_mode_i)) begin
          // stop left by another path before any wake
          state_nxt = ST_IDLE;
        end
      end
      ST_REQ: begin
        // retained stop disarms at once; very low leakage waits for acknowledge
        if (exit_start_i) begin
          if (vl_mode_r) begin
            state_nxt = ST_RECOVER;
          end else begin
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_RECOVER: begin
        // the same acknowledge clears the pin flags
        if (wake_ack_i) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt   = ST_IDLE;
        vl_mode_nxt = 1'b0;
      end
    endcase
  end

  always @* begin
    // set wins over acknowledge clear
    pin_flag_nxt = pin_wake_flag_o;
    if (wake_ack_i) begin
      pin_flag_nxt = `LWU_PIN_FLAG_RST;
    end
    if (detect) begin
      pin_flag_nxt = pin_flag_nxt | pin_qual;
    end
    // request holds until the controller starts the exit
    req_nxt = (state_nxt == ST_REQ);
    // wake interrupt left to software after leaving stop; raised from the pin flags only
    irq_nxt = (|pin_flag_nxt) && !is_low_leak(power_mode_i);
    // detecting follows the next state, so after a retained stop it drops on the exit edge itself
    det_nxt = (state_nxt != ST_IDLE);
    // core controller gated off in low leakage stop so only this unit wakes
    core_irq_nxt = !low_leak_now;
    // not sticky here: the peripheral clears its own flag
    mod_flag_nxt = detect ? mod_qual : `LWU_MOD_FLAG_RST;
  end

  // previous mode class; a reset taken inside a stop re-arms on release
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      low_leak_r <= 1'b0;
    end else begin
      low_leak_r <= low_leak_now;
    end
  end

  // state and the stop family it was armed in
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r   <= ST_IDLE;
      vl_mode_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      vl_mode_r <= vl_mode_nxt;
    end
  end

  // request and detecting status towards the power controller
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wake_req_o  <= 1'b0;
      detecting_o <= 1'b0;
    end else begin
      wake_req_o  <= req_nxt;
      detecting_o <= det_nxt;
    end
  end

  // interrupt side: core controller enable and the wake interrupt
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      core_irq_enable_o <= 1'b1;
      wake_irq_o        <= 1'b0;
    end else begin
      core_irq_enable_o <= core_irq_nxt;
      wake_irq_o        <= irq_nxt;
    end
  end

  // wake flags; pin flags are sticky, module flags follow their source
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_wake_flag_o    <= `LWU_PIN_FLAG_RST;
      module_wake_flag_o <= `LWU_MOD_FLAG_RST;
    end else begin
      pin_wake_flag_o    <= pin_flag_nxt;
      module_wake_flag_o <= mod_flag_nxt;
    end
  end

endmodule

//--- sim/lwu_props.sv
// assertions on the wake unit ports
`timescale 1ns/1ps
`include "lwu_defs.vh"
module lwu_props #(
  parameter PIN_NUM = 32,
  parameter MOD_NUM = 8
) (
  input wire                   clk_i,
  input wire                   nrst_i,
  input wire [`LWU_MODE_W-1:0] power_mode_i,
  input wire                   exit_start_i,
  input wire [PIN_NUM-1:0]     pin_wake_input_i,
  input wire [PIN_NUM-1:0]     pin_wake_enable_i,
  input wire [MOD_NUM-1:0]     module_wake_input_i,
  input wire [MOD_NUM-1:0]     module_wake_enable_i,
  input wire                   usb_host_mode_i,
  input wire                   wake_ack_i,
  input wire                   wake_req_o,
  input wire                   detecting_o,
  input wire                   core_irq_enable_o,
  input wire                   wake_irq_o,
  input wire [PIN_NUM-1:0]     pin_wake_flag_o,
  input wire [MOD_NUM-1:0]     module_wake_flag_o
);
  wire low_leak = (power_mode_i == `LWU_MODE_RSTOP) || (power_mode_i == `LWU_MODE_VLLSTOP);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  idle_no_wake_a: assert property ($rose(wake_req_o) |-> $past(detecting_o))
    else $error("wake request without arming");
  arm_on_entry_a: assert property ($rose(low_leak) |=> detecting_o)
    else $error("not armed after low leakage entry");
  core_irq_off_a: assert property (core_irq_enable_o == !$past(low_leak))
    else $error("core interrupt enable wrong");
  req_hold_a: assert property (wake_req_o && !exit_start_i |=> wake_req_o)
    else $error("wake request dropped early");
  req_drop_a: assert property (wake_req_o && exit_start_i |=> !wake_req_o)
    else $error("wake request held after exit");
  retained_off_a: assert property (
    power_mode_i == `LWU_MODE_RSTOP && exit_start_i |=> !detecting_o)
    else $error("armed after retained stop exit");
  vll_keep_a: assert property (
    power_mode_i == `LWU_MODE_VLLSTOP && exit_start_i |=> detecting_o)
    else $error("disarmed before acknowledge");
  reserved_quiet_a: assert property (~|(pin_wake_flag_o & ~`LWU_PIN_VALID_MASK))
    else $error("reserved pin input flagged");
  resv_module_a: assert property (~|(module_wake_flag_o & ~`LWU_MOD_VALID_MASK))
    else $error("reserved module input flagged");
  mod_enable_a: assert property (
    (module_wake_flag_o & ~$past(module_wake_enable_i)) == 8'h0)
    else $error("disabled module input flagged");
  cover property ($rose(wake_req_o));
  cover property (exit_start_i && power_mode_i == `LWU_MODE_RSTOP);
  cover property (exit_start_i && power_mode_i == `LWU_MODE_VLLSTOP);
  cover property ($fell(detecting_o) && $past(wake_ack_i));
endmodule
bind lwu_top lwu_props #(.PIN_NUM(PIN_NUM), .MOD_NUM(MOD_NUM)) u_props (
  .clk_i(clk_i), .nrst_i(nrst_i), .power_mode_i(power_mode_i), .exit_start_i(exit_start_i),
  .pin_wake_input_i(pin_wake_input_i), .pin_wake_enable_i(pin_wake_enable_i),
  .module_wake_input_i(module_wake_input_i), .module_wake_enable_i(module_wake_enable_i),
  .usb_host_mode_i(usb_host_mode_i), .wake_ack_i(wake_ack_i), .wake_req_o(wake_req_o),
  .detecting_o(detecting_o), .core_irq_enable_o(core_irq_enable_o), .wake_irq_o(wake_irq_o),
  .pin_wake_flag_o(pin_wake_flag_o), .module_wake_flag_o(module_wake_flag_o));

//--- sim/lwu_pmc_model.sv
// power controller model: starts the exit some cycles after a wake request
`timescale 1ns/1ps
module lwu_pmc_model #(
  parameter LAG = 2
) (
  input  wire clk_i,
  input  wire nrst_i,
  input  wire wake_req_i,
  output wire exit_start_o
);
  reg [3:0] lag_r;
  // lag models a slow supply ramp; exit only answers a standing request
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) lag_r <= 4'h0;
    else if (!wake_req_i) lag_r <= 4'h0;
    else if (lag_r != LAG) lag_r <= lag_r + 4'h1;
  end
  assign exit_start_o = wake_req_i && (lag_r == LAG);
endmodule

//--- sim/low_leakage_wakeup_unit_test.sv
// self-checking bench for the wake unit
`timescale 1ns/1ps
`define CHK(n, e, a) cmp_count++; if ((a) !== (e)) begin $display("[FAIL] %s exp %0h got %0h", n, e, a); miscompares++; end
module low_leakage_wakeup_unit_test;
  reg clk_i = 0, nrst_i = 0, usb_host_mode_i = 0, wake_ack_i = 0;
  reg [2:0] power_mode_i = 3'h0;
  reg [31:0] pin_wake_input_i = 32'h0, pin_wake_enable_i = 32'hffffffff;
  reg [7:0] module_wake_input_i = 8'h0, module_wake_enable_i = 8'h0;
  wire exit_start_i, wake_req_o, detecting_o, core_irq_enable_o, wake_irq_o;
  wire [31:0] pin_wake_flag_o;
  wire [7:0] module_wake_flag_o;
  int miscompares = 0, cmp_count = 0;
  always #2 clk_i = ~clk_i;
  lwu_top DUT (.clk_i(clk_i), .nrst_i(nrst_i), .power_mode_i(power_mode_i),
    .exit_start_i(exit_start_i), .pin_wake_input_i(pin_wake_input_i),
    .pin_wake_enable_i(pin_wake_enable_i), .module_wake_input_i(module_wake_input_i),
    .module_wake_enable_i(module_wake_enable_i), .usb_host_mode_i(usb_host_mode_i),
    .wake_ack_i(wake_ack_i), .wake_req_o(wake_req_o), .detecting_o(detecting_o),
    .core_irq_enable_o(core_irq_enable_o), .wake_irq_o(wake_irq_o),
    .pin_wake_flag_o(pin_wake_flag_o), .module_wake_flag_o(module_wake_flag_o));
  lwu_pmc_model #(.LAG(2)) u_pmc (.clk_i(clk_i), .nrst_i(nrst_i), .wake_req_i(wake_req_o),
    .exit_start_o(exit_start_i));
  task tk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task wait_req(input logic v);
    for (int i = 0; i < 20 && wake_req_o !== v; i++) tk(1);
    `CHK("wake_req", v, wake_req_o)
  endtask
  task t_idle;
    @(posedge clk_i) module_wake_input_i <= 8'h01;
    module_wake_enable_i <= 8'hff;
    tk(6);
    `CHK("idle_req", 1'b0, wake_req_o)
    `CHK("idle_det", 1'b0, detecting_o)
    `CHK("idle_flag", 8'h00, module_wake_flag_o)
    @(posedge clk_i) power_mode_i <= 3'h1;
    tk(4);
    `CHK("wait_det", 1'b0, detecting_o)
    @(posedge clk_i) power_mode_i <= 3'h2;
    tk(4);
    `CHK("stop_req", 1'b0, wake_req_o)
    `CHK("stop_det", 1'b0, detecting_o)
    `CHK("stop_core", 1'b1, core_irq_enable_o)
    @(posedge clk_i) module_wake_input_i <= 8'h0;
    power_mode_i <= 3'h0;
  endtask
  task t_retained;
    @(posedge clk_i) power_mode_i <= 3'h3;
    module_wake_input_i <= 8'h1e;
    module_wake_enable_i <= 8'h1c;
    tk(6);
    `CHK("resv_req", 1'b0, wake_req_o)
    `CHK("core_irq", 1'b0, core_irq_enable_o)
    @(posedge clk_i) module_wake_input_i <= 8'h20;
    module_wake_enable_i <= 8'hff;
    wait_req(1'b1);
    `CHK("mod_flag", 8'h20, module_wake_flag_o)
    @(posedge clk_i) module_wake_input_i <= 8'h0;
    wait_req(1'b0);
    @(posedge clk_i) module_wake_input_i <= 8'h20;
    tk(4);
    `CHK("ret_rearm", 1'b0, wake_req_o)
    `CHK("ret_off", 1'b0, detecting_o)
    `CHK("ret_flag", 8'h00, module_wake_flag_o)
    @(posedge clk_i) power_mode_i <= 3'h0;
    module_wake_input_i <= 8'h0;
    tk(4);
    `CHK("ret_det", 1'b0, detecting_o)
  endtask
  task t_vll;
    @(posedge clk_i) power_mode_i <= 3'h4;
    pin_wake_input_i <= 32'h08100000;
    tk(8);
    `CHK("usb_gate", 1'b0, wake_req_o)
    @(posedge clk_i) usb_host_mode_i <= 1'b1;
    wait_req(1'b1);
    `CHK("pin_flag", 32'h08000000, pin_wake_flag_o)
    `CHK("stop_irq", 1'b0, wake_irq_o)
    @(posedge clk_i) pin_wake_input_i <= 32'h0;
    wait_req(1'b0);
    @(posedge clk_i) power_mode_i <= 3'h0;
    tk(4);
    `CHK("vll_det", 1'b1, detecting_o)
    `CHK("wake_irq", 1'b1, wake_irq_o)
    @(posedge clk_i) wake_ack_i <= 1'b1;
    @(posedge clk_i) wake_ack_i <= 1'b0;
    tk(3);
    `CHK("ack_det", 1'b0, detecting_o)
    `CHK("ack_flag", 32'h0, pin_wake_flag_o)
    `CHK("ack_irq", 1'b0, wake_irq_o)
  endtask
  task stop_test;
    $display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_idle;
    t_retained;
    t_vll;
    stop_test;
  end
  initial begin
    #4000;
    miscompares++;
    stop_test;
  end
endmodule
